// ==== pkg/raster_pkg.sv ====
// Shared constants and types for the rasteriser walk message generator
package raster_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] XDOM_OFS = 8'h04;
	localparam logic [7:0] XSUB_OFS = 8'h08;
	localparam logic [7:0] ROW_OFS = 8'h0C;
	localparam logic [7:0] DOMSLOPE_OFS = 8'h10;
	localparam logic [7:0] SUBSLOPE_OFS = 8'h14;
	localparam logic [7:0] ROWSTEP_OFS = 8'h18;
	localparam logic [7:0] COUNT_OFS = 8'h1C;
	localparam logic [7:0] PATTERN_OFS = 8'h20;
	localparam logic [7:0] RENDER_OFS = 8'h24;
	localparam logic [7:0] POLYRES_OFS = 8'h28;
	localparam logic [7:0] MINORRES_OFS = 8'h2C;
	localparam logic [7:0] MAJORRES_OFS = 8'h30;
	localparam logic [7:0] FINE_OFS = 8'h34;
	localparam logic [7:0] COVER_OFS = 8'h38;
	localparam logic [7:0] STATUS_OFS = 8'h3C;
	// Field positions in the mode register
	localparam int MODE_MIRROR = 0;
	localparam int MODE_INVERT = 1;
	localparam int MODE_FRAC_LO = 2;
	localparam int MODE_BIAS_LO = 4;
	localparam int MODE_W = 6;
	// Field positions in the render command word
	localparam int RD_FAST = 3;
	localparam int RD_INC_LO = 4;
	localparam int RD_TYPE_LO = 6;
	localparam int RD_SYNC = 11;
	// Fixed values
	localparam logic [15:0] FRAC_HALF = 16'h8000;
	localparam logic [15:0] FRAC_NEAR_HALF = 16'h7fff;
	localparam logic [15:0] BLOCK_BASE = 16'h0008;
	localparam logic [5:0] MASK_BITS = 6'h20;
	localparam int FINE_SIGN = 4;
	localparam int COVER_W = 9;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Output message tags
	typedef enum logic [3:0] {
		TAG_PREPARE = 4'h0, TAG_VALID_H = 4'h1, TAG_VALID_E = 4'h2,
		TAG_FAILED_H = 4'h3, TAG_FAILED_E = 4'h4, TAG_FINE = 4'h5,
		TAG_BOUNDS = 4'h6, TAG_GROUP = 4'h7, TAG_COVER = 4'h8
	} tag_type;
	// Primitive shapes
	localparam logic [1:0] SHAPE_LINE = 2'h0;
	localparam logic [1:0] SHAPE_TRAP = 2'h1;
	localparam logic [1:0] SHAPE_POINT = 2'h2;
endpackage

// ==== pkg/raster_if.sv ====
// Carrier between the walk core and its bias and mask helpers
`timescale 1ns/1ps
`default_nettype none
interface raster_if;
	logic [1:0] biasSel;
	logic [2:0][31:0] raw;
	logic [2:0][31:0] loaded;
	logic [31:0] pattern;
	logic mirror;
	logic invert;
	logic tapBit;
	logic [31:0] rotated;
	modport core (output biasSel, raw, pattern, mirror, invert,
		input loaded, tapBit, rotated);
	modport bias (input biasSel, raw, output loaded);
	modport mask (input pattern, mirror, invert, output tapBit, rotated);
endinterface
`default_nettype wire

// ==== hdl/coord_bias.sv ====
// Start coordinate bias applied on the way into the interpolators
`timescale 1ns/1ps
`default_nettype none
module coord_bias
	import raster_pkg::*;
(
	raster_if.bias bus
);
	logic [31:0] addend;

	// Bias amount from the two-bit field
	always_comb begin
		case (bus.biasSel)
			2'h1: addend = {16'h0000, FRAC_HALF};
			2'h2: addend = {16'h0000, FRAC_NEAR_HALF};
			default: addend = RESET_WORD;
		endcase
	end

	// One adder per start coordinate
	for (genvar i = 0; i < 3; i++) begin : g_add
		assign bus.loaded[i] = bus.raw[i] + addend;
	end
endmodule // coord_bias
`default_nettype wire

// ==== hdl/mask_tap.sv ====
// Bitmask bit extraction, optional inversion and rotation
`timescale 1ns/1ps
`default_nettype none
module mask_tap
	import raster_pkg::*;
(
	raster_if.mask bus
);
	logic picked;

	// Mirror picks the top bit and consumes downwards
	always_comb begin
		if (bus.mirror) begin
			picked = bus.pattern[31];
			bus.rotated = {bus.pattern[30:0], bus.pattern[31]};
		end else begin
			picked = bus.pattern[0];
			bus.rotated = {bus.pattern[0], bus.pattern[31:1]};
		end
		bus.tapBit = picked ^ bus.invert;
	end
endmodule // mask_tap
`default_nettype wire

// ==== hdl/raster_walk_message_generator.sv ====
// Rasteriser output stage: walk, fill, correction and coverage messages
`timescale 1ns/1ps
`default_nettype none
module raster_walk_message_generator
	import raster_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic msgValid,
	output tag_type msgTag,
	output logic [31:0] msgData,
	input wire logic msgReady
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_PREP = 3'h1, S_POINT = 3'h2, S_LINE = 3'h3,
		S_SPAN = 3'h4, S_PIX = 3'h5, S_FILL = 3'h6, S_ROW = 3'h7
	} fsm_type;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic msgValid;
		tag_type msgTag;
		logic [31:0] msgData;
		fsm_type fsm;
		logic [MODE_W-1:0] mode;
		logic [31:0] renderData;
		logic [2:0][31:0] start;
		logic [31:0] domSlope;
		logic [31:0] subSlope;
		logic [31:0] rowStep;
		logic [15:0] countReg;
		logic [15:0] counter;
		logic [31:0] xDomAcc;
		logic [31:0] xSubAcc;
		logic [31:0] rowAcc;
		logic [15:0] xCur;
		logic [15:0] xStop;
		logic [31:0] pattern;
		logic [5:0] bitsLeft;
	} core_type;

	core_type r_reg, r_next;
	raster_if link ();
	logic canSend, doWrite, isCmd, sync, maskOk, active, last, upward;
	logic [15:0] rowInt, stepped, fillInc;
	logic [1:0] fracSel;

	coord_bias u_bias (.bus(link.bias));
	mask_tap u_mask (.bus(link.mask));

	// Helpers see the stored, unbiased start registers
	assign link.biasSel = r_reg.mode[MODE_BIAS_LO +: 2];
	assign link.raw = r_reg.start;
	assign link.pattern = r_reg.pattern;
	assign link.mirror = r_reg.mode[MODE_MIRROR];
	assign link.invert = r_reg.mode[MODE_INVERT];

	// Byte lane merge for parameter writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Walk decisions shared by every fragment state
	always_comb begin
		canSend = !r_reg.msgValid || msgReady;
		sync = r_reg.renderData[RD_SYNC];
		maskOk = !sync || (r_reg.bitsLeft != 6'h00);
		active = !sync || link.tapBit;
		rowInt = r_reg.rowAcc[31:16];
		upward = r_reg.xCur < r_reg.xStop;
		stepped = upward ? r_reg.xCur + 16'h0001 : r_reg.xCur - 16'h0001;
		last = stepped == r_reg.xStop;
		fillInc = BLOCK_BASE << r_reg.renderData[RD_INC_LO +: 2];
		fracSel = r_reg.mode[MODE_FRAC_LO +: 2];
		isCmd = adr_i inside {RENDER_OFS, POLYRES_OFS, MINORRES_OFS,
			MAJORRES_OFS, FINE_OFS, COVER_OFS};
		doWrite = cyc_i && stb_i && we_i && r_reg.ack;
	end

	// Next state: walk machine, then bus writes
	always_comb begin
		r_next = r_reg;
		r_next.ack = 1'b0;
		if (canSend) begin
			r_next.msgValid = 1'b0;
		end
		case (r_reg.fsm)
			S_IDLE: begin
			end
			// Announce the primitive before any walk message
			S_PREP: begin
				if (canSend) begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = TAG_PREPARE;
					r_next.msgData = r_reg.renderData;
					case (r_reg.renderData[RD_TYPE_LO +: 2])
						SHAPE_LINE: r_next.fsm = S_LINE;
						SHAPE_POINT: r_next.fsm = S_POINT;
						default: r_next.fsm = S_SPAN;
					endcase
				end
			end
			S_POINT: begin
				if (canSend && maskOk) begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = active ? TAG_VALID_H : TAG_FAILED_H;
					r_next.msgData = {rowInt, r_reg.xDomAcc[31:16]};
					r_next.fsm = S_IDLE;
					if (sync) begin
						r_next.pattern = link.rotated;
						r_next.bitsLeft = r_reg.bitsLeft - 6'h01;
					end
				end
			end
			// Lines step rowStep per fragment along the major edge
			S_LINE: begin
				if (r_reg.counter == 16'h0000) begin
					r_next.fsm = S_IDLE;
				end else if (canSend && maskOk) begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = active ? TAG_VALID_E : TAG_FAILED_E;
					r_next.msgData = {rowInt, r_reg.xDomAcc[31:16]};
					r_next.xDomAcc = r_reg.xDomAcc + r_reg.domSlope;
					r_next.rowAcc = r_reg.rowAcc + r_reg.rowStep;
					r_next.counter = r_reg.counter - 16'h0001;
					if (sync) begin
						r_next.pattern = link.rotated;
						r_next.bitsLeft = r_reg.bitsLeft - 6'h01;
					end
				end
			end
			// Span set-up; the far edge itself is not plotted
			S_SPAN: begin
				if (r_reg.counter == 16'h0000) begin
					r_next.fsm = S_IDLE;
				end else begin
					r_next.xCur = r_reg.xDomAcc[31:16];
					r_next.xStop = r_reg.xSubAcc[31:16];
					if (r_reg.xDomAcc[31:16] == r_reg.xSubAcc[31:16]) begin
						r_next.fsm = S_ROW;
					end else if (!r_reg.renderData[RD_FAST]) begin
						r_next.fsm = S_PIX;
					end else if (r_reg.xDomAcc[31:16] >
						r_reg.xSubAcc[31:16]) begin
						r_next.fsm = S_ROW;
					end else if (canSend) begin
						r_next.msgValid = 1'b1;
						r_next.msgTag = TAG_BOUNDS;
						r_next.msgData = {r_reg.xSubAcc[31:16],
							r_reg.xDomAcc[31:16]};
						r_next.fsm = S_FILL;
					end
				end
			end
			// Stall here while the mask is used up
			S_PIX: begin
				if (canSend && maskOk) begin
					r_next.msgValid = 1'b1;
					if (last) begin
						r_next.msgTag = active ? TAG_VALID_E : TAG_FAILED_E;
						r_next.fsm = S_ROW;
					end else begin
						r_next.msgTag = active ? TAG_VALID_H : TAG_FAILED_H;
					end
					r_next.msgData = {rowInt, r_reg.xCur};
					r_next.xCur = stepped;
					if (sync) begin
						r_next.pattern = link.rotated;
						r_next.bitsLeft = r_reg.bitsLeft - 6'h01;
					end
				end
			end
			S_FILL: begin
				if (r_reg.xCur >= r_reg.xStop) begin
					r_next.fsm = S_ROW;
				end else if (canSend) begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = TAG_GROUP;
					r_next.msgData = {rowInt, r_reg.xCur};
					r_next.xCur = r_reg.xCur + fillInc;
				end
			end
			// Only the accumulators and the counter move, never the parameters
			S_ROW: begin
				r_next.xDomAcc = r_reg.xDomAcc + r_reg.domSlope;
				r_next.xSubAcc = r_reg.xSubAcc + r_reg.subSlope;
				r_next.rowAcc = r_reg.rowAcc + r_reg.rowStep;
				r_next.counter = r_reg.counter - 16'h0001;
				r_next.fsm = S_SPAN;
			end
			default: r_next.fsm = S_IDLE;
		endcase

		// Commands wait for an idle walk and a free output
		if (cyc_i && stb_i && !r_reg.ack &&
			(!(we_i && isCmd) || (r_reg.fsm == S_IDLE && canSend))) begin
			r_next.ack = 1'b1;
			case (adr_i)
				XDOM_OFS: r_next.rdat = r_reg.start[0];
				XSUB_OFS: r_next.rdat = r_reg.start[1];
				ROW_OFS: r_next.rdat = r_reg.start[2];
				DOMSLOPE_OFS: r_next.rdat = r_reg.domSlope;
				SUBSLOPE_OFS: r_next.rdat = r_reg.subSlope;
				ROWSTEP_OFS: r_next.rdat = r_reg.rowStep;
				COUNT_OFS: r_next.rdat = {16'h0000, r_reg.countReg};
				PATTERN_OFS: r_next.rdat = r_reg.pattern;
				STATUS_OFS: r_next.rdat = {r_reg.counter, 2'h0,
					r_reg.bitsLeft, 7'h00, r_reg.fsm != S_IDLE};
				default: r_next.rdat = RESET_WORD;
			endcase
		end

		// Writes land on the edge that sees the acknowledge
		if (doWrite) begin
			case (adr_i)
				MODE_OFS: r_next.mode = dat_i[MODE_W-1:0];
				XDOM_OFS: r_next.start[0] = merge(r_reg.start[0], dat_i, sel_i);
				XSUB_OFS: r_next.start[1] = merge(r_reg.start[1], dat_i, sel_i);
				ROW_OFS: r_next.start[2] = merge(r_reg.start[2], dat_i, sel_i);
				DOMSLOPE_OFS: r_next.domSlope = merge(r_reg.domSlope, dat_i, sel_i);
				SUBSLOPE_OFS: r_next.subSlope = merge(r_reg.subSlope, dat_i, sel_i);
				ROWSTEP_OFS: r_next.rowStep = merge(r_reg.rowStep, dat_i, sel_i);
				COUNT_OFS: r_next.countReg = dat_i[15:0];
				PATTERN_OFS: begin
					r_next.pattern = dat_i;
					r_next.bitsLeft = MASK_BITS;
				end
				// Undefined shape code is dropped silently
				RENDER_OFS: begin
					if (dat_i[RD_TYPE_LO +: 2] != 2'h3) begin
						r_next.renderData = dat_i;
						r_next.xDomAcc = link.loaded[0];
						r_next.xSubAcc = link.loaded[1];
						r_next.rowAcc = link.loaded[2];
						r_next.counter = r_reg.countReg;
						r_next.fsm = S_PREP;
					end
				end
				// Position carries on; only fractions are forced
				POLYRES_OFS: begin
					r_next.counter = dat_i[15:0];
					case (fracSel)
						2'h1: begin
							r_next.xDomAcc[15:0] = 16'h0000;
							r_next.rowAcc[15:0] = 16'h0000;
						end
						2'h2: begin
							r_next.xDomAcc[15:0] = FRAC_HALF;
							r_next.rowAcc[15:0] = FRAC_HALF;
						end
						2'h3: begin
							r_next.xDomAcc[15:0] = FRAC_NEAR_HALF;
							r_next.rowAcc[15:0] = FRAC_NEAR_HALF;
						end
						default: begin
						end
					endcase
					r_next.fsm = S_LINE;
				end
				MINORRES_OFS: begin
					r_next.xSubAcc = link.loaded[1];
					r_next.counter = dat_i[15:0];
					r_next.fsm = (dat_i[15:0] == 16'h0000) ? S_IDLE : S_SPAN;
				end
				MAJORRES_OFS: begin
					r_next.xDomAcc = link.loaded[0];
					r_next.counter = dat_i[15:0];
					r_next.fsm = S_SPAN;
				end
				FINE_OFS: begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = TAG_FINE;
					r_next.msgData = {27'h000_0000, dat_i[FINE_SIGN:0]};
				end
				COVER_OFS: begin
					r_next.msgValid = 1'b1;
					r_next.msgTag = TAG_COVER;
					r_next.msgData = {23'h00_0000, dat_i[COVER_W-1:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// Single state register, frozen while ce is low and rstn is high
	always_ff @(posedge clk) begin
		if (!rstn) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign dat_o = r_reg.rdat;
	assign ack_o = r_reg.ack;
	assign msgValid = r_reg.msgValid;
	assign msgTag = r_reg.msgTag;
	assign msgData = r_reg.msgData;

	// Helper: a prepare has gone out since the last render command;
	// resumes continue the primitive and need no fresh prepare
	logic prepSeen;
	always_ff @(posedge clk) begin
		if (!rstn || (ce && doWrite && adr_i == RENDER_OFS)) begin
			prepSeen <= 1'b0;
		end else if (r_reg.msgValid && r_reg.msgTag == TAG_PREPARE) begin
			prepSeen <= 1'b1;
		end
	end

	sequence pixFire_s;
		ce && r_reg.fsm == S_PIX && canSend && maskOk;
	endsequence
	sequence cmdWrite_s(logic [7:0] ofs);
		ce && doWrite && adr_i == ofs;
	endsequence

	prep_before_walk_a: assert property (@(posedge clk) disable iff (!rstn)
		msgValid && msgTag inside {TAG_VALID_E, TAG_FAILED_E}
		&& r_reg.fsm != S_IDLE |-> prepSeen)
		else $error("walk message without prepare");
	pix_coord_a: assert property (@(posedge clk) disable iff (!rstn)
		pixFire_s |=> msgData == {$past(rowInt), $past(r_reg.xCur)})
		else $error("fragment coordinate wrong");
	pix_variant_a: assert property (@(posedge clk) disable iff (!rstn)
		pixFire_s and !last |=> msgTag == ($past(active) ?
		TAG_VALID_H : TAG_FAILED_H))
		else $error("step variant wrong");
	mask_invert_a: assert property (@(posedge clk) disable iff (!rstn)
		pixFire_s and sync |-> active == ((r_reg.mode[MODE_MIRROR] ?
		r_reg.pattern[31] : r_reg.pattern[0]) ^ r_reg.mode[MODE_INVERT]))
		else $error("mask bit not inverted");
	start_kept_a: assert property (@(posedge clk) disable iff (!rstn)
		cmdWrite_s(RENDER_OFS) |=> $stable(r_reg.start))
		else $error("start register changed");
	frac_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		cmdWrite_s(POLYRES_OFS) and fracSel == 2'h1 |=>
		r_reg.xDomAcc[15:0] == 16'h0000 && r_reg.rowAcc[15:0] == 16'h0000)
		else $error("fraction not cleared");
	minor_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		cmdWrite_s(MINORRES_OFS) and dat_i[15:0] == 16'h0000 |=>
		r_reg.fsm == S_IDLE ##1 !msgValid)
		else $error("rows drawn on zero count");
	cover_width_a: assert property (@(posedge clk) disable iff (!rstn)
		cmdWrite_s(COVER_OFS) |=> msgValid && msgTag == TAG_COVER
		&& msgData[31:COVER_W] == 23'h00_0000)
		else $error("coverage message malformed");
	msg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		msgValid && !msgReady |=> msgValid && $stable(msgData)
		&& $stable(msgTag))
		else $error("message dropped under stall");
endmodule // raster_walk_message_generator
`default_nettype wire

// ==== sim/msg_sink.sv ====
// Downstream message receiver model that logs traffic and can stall
`timescale 1ns/1ps
`default_nettype none
module msg_sink
	import raster_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic msgValid,
	input wire tag_type msgTag,
	input wire logic [31:0] msgData,
	output logic msgReady
);
	tag_type tagLog [0:127];
	logic [31:0] dataLog [0:127];
	logic [31:0] boundsReg = 32'h0000_0000;
	int cnt = 0;
	int holdErr = 0;
	logic toggleReg = 1'h0;
	logic stallReg = 1'h0;
	tag_type tagReg;
	logic [31:0] dataReg;
	// Slow pace accepts every other cycle, so held outputs get exercised
	assign msgReady = ~slow | toggleReg;
	// Any tag order is taken, prepare then steps alone too
	always @(posedge clk) begin
		toggleReg <= ~toggleReg;
		stallReg <= rstn & msgValid & ~msgReady;
		tagReg <= msgTag;
		dataReg <= msgData;
		if (stallReg && (msgValid !== 1'h1 || msgTag !== tagReg
			|| msgData !== dataReg)) begin
			holdErr <= holdErr + 1;
		end
		if (rstn && msgValid && msgReady) begin
			tagLog[cnt] <= msgTag;
			dataLog[cnt] <= msgData;
			cnt <= cnt + 1;
			// Latest bounds message kept in boundsReg; nothing reads it back
			if (msgTag == TAG_BOUNDS) begin
				boundsReg <= msgData;
			end
		end
	end
endmodule // msg_sink
`default_nettype wire

// ==== sim/tb_raster_walk_message_generator.sv ====
// Self-checking bench for the rasteriser walk message generator
`timescale 1ns/1ps
`default_nettype none
module tb_raster_walk_message_generator
	import raster_pkg::*;
;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic ce = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic slow = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] datO, msgData, rd, xa, ya;
	logic ack, msgValid, msgReady;
	tag_type msgTag;
	int failures = 0;
	int cmpCount = 0;
	int idx = 0;
	int f, n;
	always #4 clk = ~clk;
	raster_walk_message_generator dut (.clk(clk), .rstn(rstn), .ce(ce),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dat), .dat_o(datO), .ack_o(ack), .msgValid(msgValid),
		.msgTag(msgTag), .msgData(msgData), .msgReady(msgReady));
	msg_sink sink (.clk(clk), .rstn(rstn), .slow(slow), .msgValid(msgValid),
		.msgTag(msgTag), .msgData(msgData), .msgReady(msgReady));
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	// One classic cycle; command writes may wait long while walking
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'h1 && k < 4000);
		if (k >= 4000) chk("ack", 32'h0000_0000, 32'h0000_0001);
		rd = datO;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	// Waits for the next logged message under a bound, then compares
	task automatic msg(input tag_type t, input logic [31:0] d);
		int k;
		k = 0;
		while (sink.cnt <= idx && k < 4000) begin
			@(posedge clk);
			k++;
		end
		chk("msgTag", 32'(sink.tagLog[idx]), 32'(t));
		chk("msgData", sink.dataLog[idx], d);
		idx++;
	endtask
	// Line walk expectation: X steps 1.0, row steps 0.5
	task automatic lw(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			msg(TAG_VALID_E, {ya[31:16], xa[31:16]});
			xa += 32'h0001_0000;
			ya += 32'h0000_8000;
		end
	endtask
	task automatic pt(input logic [5:0] m, input logic [31:0] p, x, r,
		input tag_type t, input logic [15:0] ex);
		wr(MODE_OFS, {26'h000_0000, m});
		wr(PATTERN_OFS, p);
		if (x != 32'h0000_0000) wr(XDOM_OFS, x);
		wr(RENDER_OFS, r);
		msg(TAG_PREPARE, r);
		msg(t, {16'h0007, ex});
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		bus(1'h0, STATUS_OFS, 32'h0000_0000);
		chk("status", rd, RESET_WORD);
		bus(1'h0, 8'h40, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		done("reset");
		// Points through bias codes, stored start kept, mask variants
		wr(ROW_OFS, 32'h0007_0000);
		pt(6'h10, 32'h0, 32'h0005_8000, 32'h0000_0080, TAG_VALID_H, 16'h0006);
		pt(6'h20, 32'h0, 32'h0, 32'h0000_0080, TAG_VALID_H, 16'h0005);
		pt(6'h20, 32'h0, 32'h0005_8001, 32'h0000_0080, TAG_VALID_H, 16'h0006);
		pt(6'h00, 32'h0, 32'h0, 32'h0000_0080, TAG_VALID_H, 16'h0005);
		pt(6'h00, 32'h1, 32'h0, 32'h0000_0880, TAG_VALID_H, 16'h0005);
		pt(6'h02, 32'h1, 32'h0, 32'h0000_0880, TAG_FAILED_H, 16'h0005);
		pt(6'h01, 32'h1, 32'h0, 32'h0000_0880, TAG_FAILED_H, 16'h0005);
		pt(6'h01, 32'h8000_0000, 32'h0, 32'h0000_0880, TAG_VALID_H, 16'h0005);
		done("points");
		// Line then polyline resumes; no exact interpolation here
		// Thin lines only, so no dash state handling is needed
		wr(MODE_OFS, 32'h0000_0000);
		wr(XDOM_OFS, 32'h0005_0000);
		wr(DOMSLOPE_OFS, 32'h0001_0000);
		wr(ROWSTEP_OFS, 32'h0000_8000);
		wr(COUNT_OFS, 32'h0000_0003);
		wr(RENDER_OFS, 32'h0000_0000);
		msg(TAG_PREPARE, 32'h0000_0000);
		xa = 32'h0005_0000;
		ya = 32'h0007_0000;
		lw(3);
		for (f = 0; f < 4; f++) begin
			wr(MODE_OFS, 32'(f << MODE_FRAC_LO));
			if (f != 0) begin
				xa[15:0] = (f == 1) ? 16'h0000 : (f == 2) ? FRAC_HALF : FRAC_NEAR_HALF;
				ya[15:0] = xa[15:0];
			end
			wr(POLYRES_OFS, 32'h0000_0002);
			lw(2);
		end
		// Count and start registers survive the walks
		wr(RENDER_OFS, 32'h0000_0000);
		msg(TAG_PREPARE, 32'h0000_0000);
		xa = 32'h0005_0000;
		ya = 32'h0007_0000;
		lw(3);
		done("line");
		// Trapezoid span with a stalling receiver
		slow <= 1'h1;
		wr(MODE_OFS, 32'h0000_0000);
		wr(XDOM_OFS, 32'h0003_0000);
		wr(XSUB_OFS, 32'h0006_0000);
		wr(ROW_OFS, 32'h0002_0000);
		wr(DOMSLOPE_OFS, 32'h0000_0000);
		wr(SUBSLOPE_OFS, 32'h0000_0000);
		wr(ROWSTEP_OFS, 32'h0001_0000);
		wr(COUNT_OFS, 32'h0000_0001);
		wr(RENDER_OFS, 32'h0000_0040);
		msg(TAG_PREPARE, 32'h0000_0040);
		msg(TAG_VALID_H, 32'h0002_0003);
		msg(TAG_VALID_H, 32'h0002_0004);
		msg(TAG_VALID_E, 32'h0002_0005);
		wr(MINORRES_OFS, 32'h0000_0000);
		wr(RENDER_OFS, 32'h0000_00C0);
		repeat (40) @(posedge clk);
		chk("msgCount", 32'(sink.cnt), 32'(idx));
		chk("holdErr", 32'(sink.holdErr), 32'h0000_0000);
		done("trapezoid");
		// Fast fill: bounds then groups
		slow <= 1'h0;
		wr(XDOM_OFS, 32'h000A_0000);
		wr(XSUB_OFS, 32'h0028_0000);
		wr(RENDER_OFS, 32'h0000_0048);
		msg(TAG_PREPARE, 32'h0000_0048);
		msg(TAG_BOUNDS, 32'h0028_000A);
		n = 0;
		do begin
			bus(1'h0, STATUS_OFS, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'h0 && n < 500);
		repeat (4) @(posedge clk);
		chk("groupTag", 32'(sink.tagLog[idx]), 32'(TAG_GROUP));
		chk("groupRow", {16'h0000, sink.dataLog[idx][31:16]}, 32'h0000_0002);
		idx = sink.cnt;
		done("fastfill");
		// Formatted software-supplied messages, fine offset once
		wr(FINE_OFS, 32'h0000_0013);
		msg(TAG_FINE, 32'h0000_0013);
		wr(COVER_OFS, 32'h0000_0100);
		msg(TAG_COVER, 32'h0000_0100);
		done("fine_cover");
		final_report();
	end
endmodule // tb_raster_walk_message_generator
`default_nettype wire
